// ---- core/fbsp_pkg.sv ----
// Package with register map, field positions, timing counts and types of the four-bit serial port.
`default_nettype none

package fbsp_pkg;

    // ==========================================================================
    // Register map (byte addresses on the APB bus)
    // ==========================================================================
    localparam logic [11:0] ADDR_COMMAND = 12'h000;
    localparam logic [11:0] ADDR_BUFFER = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;

    localparam int CMD_ENABLE_BIT = 3;
    localparam int CMD_RECEIVE_BIT = 2;
    localparam int CMD_EDGE_BIT = 1;
    localparam int CMD_CLOCK_BIT = 0;
    localparam logic [3:0] COMMAND_RESET = 4'h0;

    localparam int STAT_ACTIVE_BIT = 3;
    localparam int STAT_UNDERWAY_BIT = 2;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_IRQ_BIT = 0;

    // ==========================================================================
    // Word size and timing
    // ==========================================================================
    localparam int WORD_BITS = 4;
    localparam logic [2:0] LAST_BIT_COUNT = 3'(WORD_BITS);
    localparam int RATE_LIMIT_BPS = 31250;
    localparam int REF_BASIC_HZ = 4_000_000;
    localparam int SCK_DIVIDE = REF_BASIC_HZ / RATE_LIMIT_BPS;
    localparam int SCK_HALF_CYCLES = SCK_DIVIDE / 2;
    localparam logic [5:0] SCK_HALF_MAX = 6'(SCK_HALF_CYCLES - 1);

    // ==========================================================================
    // Types
    // ==========================================================================
    typedef enum logic [1:0] {MODE_UNUSED, MODE_TX, MODE_RX_TRAIL, MODE_RX_LEAD} fbsp_mode_type;
    typedef enum logic {ST_IDLE, ST_RUN} fbsp_state_type;

    function automatic fbsp_mode_type decode_mode(input logic receive_sel, input logic edge_sel);
        fbsp_mode_type m;
        m = MODE_UNUSED;
        if (receive_sel && edge_sel) begin
            m = MODE_RX_LEAD;
        end else if (receive_sel) begin
            m = MODE_RX_TRAIL;
        end else if (edge_sel) begin
            m = MODE_TX;
        end
        return m;
    endfunction : decode_mode

endpackage : fbsp_pkg

`default_nettype wire

// ---- core/fbsp_sck_gen.sv ----
// Internal shift clock generator: divides pclk by the shift divider and halts high on request.
`default_nettype none

module fbsp_sck_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    output logic sck,
    output logic lead,
    output logic trail
);

    logic [5:0] half_cnt;

    // ==========================================================================
    // Divider
    // ==========================================================================
    // The clock may only stop while high, so a low phase always runs to its end.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt <= 6'h00;
            sck <= 1'b1;
            lead <= 1'b0;
            trail <= 1'b0;
        end else begin
            lead <= 1'b0;
            trail <= 1'b0;
            if (go || !sck) begin
                if (half_cnt == fbsp_pkg::SCK_HALF_MAX) begin
                    half_cnt <= 6'h00;
                    sck <= !sck;
                    lead <= sck;
                    trail <= !sck;
                end else begin
                    half_cnt <= half_cnt + 6'h01;
                end
            end else begin
                half_cnt <= 6'h00;
            end
        end
    end

endmodule : fbsp_sck_gen

`default_nettype wire

// ---- core/fbsp_top.sv ----
// Four-bit serial port with shift register, buffer register, APB registers and shift clock control.
`default_nettype none

// What this block does
// [R01] Receive and edge bits pick unused, transmit, trailing or leading receive; bit 0 clock source.
// [R02] Command register at its own address, cleared by reset, top bit enables.
// [R03] Transmit sends the four buffered bits least significant bit first.
// [R04] Internal shift clock is the basic clock divided by 128, driven on the pin.
// [R05] With external clock, software refills the buffer before the next word starts.
// [R06] Buffer becoming empty in transmit raises the serial interrupt.
// [R07] Clearing enable without new data stops after the current word is fully sent.
// [R08] Status top bit shows whether a transfer is still in progress.
// [R09] With external clock, software clears enable before the next word would start.
// [R10] Internal clock already waiting: clearing enable ends the transfer at once.
// [R11] For one word, software clears enable in the buffer-empty service routine.
// [R12] Receive copies each complete word to the buffer and raises buffer-full interrupt.
// [R13] After handing a word over, receive keeps shifting without waiting for a read.
// [R14] Reading the buffer clears the interrupt and moves in a waiting word.
// [R15] Internal clock receive halts the shift clock while a word waits on a full buffer.
// [R16] Internal receive rate never exceeds the basic clock over 128.
// [R17] With external clock, software reads the buffer before the next word lands.
// [R18] Software keeps the mode until the last word has been read.
// [R19] Slow external clock: clear enable in the last word's routine, then read.
// [R20] Fast rates: clear enable after underway flag is one, in next-to-last routine.
// [R21] Fast external clock: clear enable and read before the last word lands.
// [R22] Single word receive gives exactly one buffer-full interrupt, which software reads.
// [R23] Leading receive equals trailing receive but samples on the leading edge.
// [R24] Underway flag is one once a word has started shifting, zero when idle.
module fbsp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic sdi,
    output logic sdo,
    output logic serial_interrupt
);

    // ==========================================================================
    // Declarations
    // ==========================================================================
    logic [3:0] command;
    logic [3:0] buffer;
    logic [3:0] shifter;
    logic [3:0] pend_word;
    logic buf_full;
    logic pend;
    logic [2:0] bit_cnt;
    logic sck_in_prev;
    fbsp_pkg::fbsp_state_type state;
    fbsp_pkg::fbsp_mode_type mode;
    logic serial_enable;
    logic clock_source_select;
    logic run;
    logic tx_mode;
    logic rx_mode;
    logic gen_go;
    logic gen_lead;
    logic gen_trail;
    logic lead_edge;
    logic trail_edge;
    logic sample_edge;
    logic setup;
    logic access;
    logic wr_cmd;
    logic wr_buf;
    logic rd_buf;
    logic tx_boundary;
    logic tx_load;
    logic tx_stop;
    logic rx_stop;
    logic word_done;
    logic [3:0] word_in;
    logic buf_free;
    logic shift_underway_flag;
    logic [31:0] next_prdata;
    logic next_unmapped;

    assign serial_enable = command[fbsp_pkg::CMD_ENABLE_BIT];
    assign clock_source_select = command[fbsp_pkg::CMD_CLOCK_BIT];
    assign mode = fbsp_pkg::decode_mode(command[fbsp_pkg::CMD_RECEIVE_BIT], command[fbsp_pkg::CMD_EDGE_BIT]); // [R01]
    assign tx_mode = (mode == fbsp_pkg::MODE_TX);
    assign rx_mode = (mode == fbsp_pkg::MODE_RX_TRAIL) || (mode == fbsp_pkg::MODE_RX_LEAD);
    assign run = (state == fbsp_pkg::ST_RUN);
    assign shift_underway_flag = run && (bit_cnt != 3'h0); // [R24]

    // ==========================================================================
    // Shift clock selection
    // ==========================================================================
    // The external pin is synchronous to pclk; the leading edge of the active-low
    // shift clock is its falling edge.
    assign lead_edge = run && (clock_source_select ? gen_lead : (sck_in_prev && !sck_in)); // [R01]
    assign trail_edge = run && (clock_source_select ? gen_trail : (!sck_in_prev && sck_in));
    assign sample_edge = (mode == fbsp_pkg::MODE_RX_LEAD) ? lead_edge : trail_edge; // [R23]

    // Wait: the generator holds the clock high while transmit lacks data or a
    // received word is parked behind an unread buffer.
    assign gen_go = run && clock_source_select && !tx_stop && !rx_stop
        && !(tx_mode && tx_boundary && !buf_full)
        && !(rx_mode && pend); // [R15]

    fbsp_sck_gen u_sck_gen (
        .pclk(pclk),
        .presetn(presetn),
        .go(gen_go),
        .sck(sck_out),
        .lead(gen_lead),
        .trail(gen_trail)
    ); // [R04]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_in_prev <= 1'b1;
            sck_oe <= 1'b0;
        end else begin
            sck_in_prev <= sck_in;
            sck_oe <= clock_source_select; // [R04]
        end
    end

    // ==========================================================================
    // APB decode
    // ==========================================================================
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr_cmd = access && pwrite && (paddr == fbsp_pkg::ADDR_COMMAND);
    assign wr_buf = access && pwrite && (paddr == fbsp_pkg::ADDR_BUFFER) && tx_mode;
    assign rd_buf = access && !pwrite && (paddr == fbsp_pkg::ADDR_BUFFER) && rx_mode;

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_unmapped = 1'b0;
        if (paddr == fbsp_pkg::ADDR_COMMAND) begin
            next_prdata[3:0] = command;
        end else if (paddr == fbsp_pkg::ADDR_BUFFER) begin
            next_prdata[3:0] = buffer;
        end else if (paddr == fbsp_pkg::ADDR_STATUS) begin
            next_prdata[fbsp_pkg::STAT_ACTIVE_BIT] = run; // [R08]
            next_prdata[fbsp_pkg::STAT_UNDERWAY_BIT] = shift_underway_flag;
            next_prdata[fbsp_pkg::STAT_FULL_BIT] = buf_full;
            next_prdata[fbsp_pkg::STAT_IRQ_BIT] = serial_interrupt;
        end else begin
            next_unmapped = 1'b1;
        end
    end

    // Answers come from flops, so every transfer has exactly one access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && next_unmapped;
            prdata <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command <= fbsp_pkg::COMMAND_RESET; // [R02]
        end else if (wr_cmd) begin
            command <= pwdata[3:0];
        end
    end

    // ==========================================================================
    // Transfer sequencing
    // ==========================================================================
    assign tx_boundary = (bit_cnt == 3'h0) || (bit_cnt == fbsp_pkg::LAST_BIT_COUNT);
    assign tx_load = run && tx_mode && lead_edge && tx_boundary && buf_full;
    // The last bit stays on the line until its period ends: the next leading edge,
    // or the halted internal clock sitting high.
    assign tx_stop = run && tx_mode && tx_boundary && !buf_full && !serial_enable
        && ((bit_cnt == 3'h0) || lead_edge || (clock_source_select && sck_out)); // [R07] [R10]
    assign rx_stop = run && rx_mode && (bit_cnt == 3'h0) && !serial_enable && !sample_edge;
    assign word_in = {sdi, shifter[3:1]};
    assign word_done = run && rx_mode && sample_edge && (bit_cnt == (fbsp_pkg::LAST_BIT_COUNT - 3'h1));
    assign buf_free = !buf_full || rd_buf;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= fbsp_pkg::ST_IDLE;
        end else if (!run && serial_enable && (tx_mode || rx_mode)) begin
            state <= fbsp_pkg::ST_RUN; // [R01]
        end else if (tx_stop || rx_stop) begin
            state <= fbsp_pkg::ST_IDLE; // [R07] [R10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= 3'h0;
            shifter <= 4'h0;
            sdo <= 1'b1;
        end else if (!run) begin
            bit_cnt <= 3'h0;
        end else if (tx_mode && lead_edge) begin
            if (tx_load) begin
                shifter <= buffer;
                sdo <= buffer[0]; // [R03]
                bit_cnt <= 3'h1;
            end else if (tx_boundary) begin
                bit_cnt <= 3'h0;
            end else begin
                shifter <= {1'b0, shifter[3:1]};
                sdo <= shifter[1]; // [R03]
                bit_cnt <= bit_cnt + 3'h1;
            end
        end else if (rx_mode && sample_edge) begin
            // Shifting goes on after a word completes; no wait on the reader.
            shifter <= word_in; // [R13]
            bit_cnt <= word_done ? 3'h0 : bit_cnt + 3'h1;
        end
    end

    // ==========================================================================
    // Buffer register and interrupt
    // ==========================================================================
    // Set wins over clear: a hardware event in the cycle of the clearing access
    // leaves the interrupt raised.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer <= 4'h0;
            buf_full <= 1'b0;
            pend <= 1'b0;
            pend_word <= 4'h0;
            serial_interrupt <= 1'b0;
        end else begin
            if (tx_mode) begin
                if (wr_buf) begin
                    buffer <= pwdata[3:0];
                    buf_full <= 1'b1;
                end else if (tx_load) begin
                    buf_full <= 1'b0;
                end
                if (tx_load) begin
                    serial_interrupt <= 1'b1; // [R06]
                end else if (wr_buf) begin
                    serial_interrupt <= 1'b0;
                end
            end else if (rx_mode) begin
                if (rd_buf && pend) begin
                    buffer <= pend_word; // [R14]
                    buf_full <= 1'b1;
                    serial_interrupt <= 1'b1;
                end else if (word_done && buf_free) begin
                    buffer <= word_in; // [R12]
                    buf_full <= 1'b1;
                    serial_interrupt <= 1'b1;
                end else if (rd_buf) begin
                    buf_full <= 1'b0; // [R14]
                    serial_interrupt <= 1'b0;
                end
                if (word_done && (!buf_free || pend)) begin
                    pend <= 1'b1;
                    pend_word <= word_in;
                end else if (rd_buf) begin
                    pend <= 1'b0;
                end
            end
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    default clocking chk_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_mode_gate: assert property ($rose(run) |-> $past(tx_mode || rx_mode) && $past(serial_enable)) // [R01]
        else $error("Transfer started in an unusable mode or while disabled.");
    chk_cmd_write: assert property (wr_cmd |=> command == $past(pwdata[3:0])) // [R02]
        else $error("Command write did not take effect.");
    chk_tx_lsb: assert property (tx_load |=> sdo == $past(buffer[0])) // [R03]
        else $error("Transmit did not start with the least significant bit.");
    chk_sck_low_phase: assert property ($fell(sck_out) |-> !sck_out ##64 $rose(sck_out)) // [R04]
        else $error("Internal shift clock low phase is not 64 cycles.");
    chk_sck_high_min: assert property ($rose(sck_out) |-> ##63 sck_out) // [R16]
        else $error("Internal shift clock high phase shorter than 64 cycles.");
    chk_tx_empty_irq: assert property (tx_load && !wr_buf |=> serial_interrupt && !buf_full) // [R06]
        else $error("Buffer empty did not raise the interrupt.");
    chk_word_completes: assert property (run && tx_mode && (bit_cnt inside {3'h1, 3'h2, 3'h3}) |=> run) // [R07]
        else $error("Transmit stopped in the middle of a word.");
    chk_status_active: assert property (setup && !pwrite && paddr == fbsp_pkg::ADDR_STATUS
        |=> prdata[fbsp_pkg::STAT_ACTIVE_BIT] == $past(run)) // [R08]
        else $error("Status top bit does not follow the transfer state.");
    chk_wait_abort: assert property (run && tx_mode && clock_source_select && sck_out && !buf_full
        && !serial_enable && bit_cnt == fbsp_pkg::LAST_BIT_COUNT |=> !run) // [R10]
        else $error("Halted transmit did not end at once on disable.");
    chk_rx_word_load: assert property (word_done && !buf_full && !pend
        |=> buf_full && serial_interrupt && buffer == $past(word_in)) // [R12]
        else $error("Received word did not reach the buffer with an interrupt.");
    chk_rx_continues: assert property (word_done && serial_enable |=> run && bit_cnt == 3'h0) // [R13]
        else $error("Receive stopped after a word while still enabled.");
    chk_read_clear: assert property (rd_buf && !pend && !word_done |=> !serial_interrupt && !buf_full) // [R14]
        else $error("Buffer read did not clear the interrupt.");
    chk_read_refill: assert property (rd_buf && pend && !word_done |=> buf_full && serial_interrupt && !pend) // [R14]
        else $error("Waiting word was not moved in after the read.");
    chk_rx_halt: assert property (rx_mode && pend && clock_source_select && sck_out |=> sck_out) // [R15]
        else $error("Shift clock ran while a word waited on a full buffer.");
    chk_underway: assert property (tx_load |=> shift_underway_flag) // [R24]
        else $error("Underway flag not set once shifting began.");
    chk_idle_quiet: assert property (!run |-> !shift_underway_flag) // [R24]
        else $error("Underway flag set while idle.");

    cov_tx_word: cover property (tx_load ##[1:1000] tx_stop);
    cov_rx_single: cover property ($rose(run) && rx_mode ##[1:1000] word_done ##[1:1000] rd_buf); // [R22]
    cov_rx_lead: cover property (mode == fbsp_pkg::MODE_RX_LEAD && word_done); // [R23]
    cov_rx_pend: cover property (pend ##[1:1000] rd_buf);

endmodule : fbsp_top

`default_nettype wire

// ---- dv/fbsp_far_end.sv ----
// Far-end model: an external serial circuit that clocks words in and watches the data line.
`default_nettype none

module fbsp_far_end #(
    parameter int HALF = 8
) (
    input wire logic pclk,
    input wire logic sck_pin,
    input wire logic sdo,
    output logic sck_in,
    output logic sdi,
    output logic [3:0] seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Line drivers
    // =========================================================
    logic busy;
    initial begin
        sck_in = 1'b1;
        sdi = 1'b0;
        busy = 1'b0;
        seen = 4'h0;
    end
    // Outside a frame the data line is not held, so it shows a changing pattern.
    always @(posedge pclk) begin
        if (!busy) begin
            sdi <= ~sdi;
        end
    end
    // The clock idles high and runs only inside a frame; each bit is set up before its leading edge.
    task automatic send(input logic [3:0] w);
        busy = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            sdi <= w[i];
            repeat (HALF) @(posedge pclk);
            sck_in <= 1'b0;
            repeat (HALF) @(posedge pclk);
            sck_in <= 1'b1;
        end
        repeat (HALF) @(posedge pclk);
        busy = 1'b0;
    endtask : send
    always @(posedge sck_pin) begin
        seen <= {sdo, seen[3:1]};
    end
endmodule : fbsp_far_end

`default_nettype wire

// ---- dv/tb_top.sv ----
// Testbench for the four-bit serial port: registers, transmit and both receive edges.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [11:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] exp;
        logic err;
    } fbsp_row_type;
    localparam logic [11:0] CMD = fbsp_pkg::ADDR_COMMAND;
    localparam logic [11:0] BUF = fbsp_pkg::ADDR_BUFFER;
    localparam logic [11:0] STA = fbsp_pkg::ADDR_STATUS;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sck_out, sck_oe, sdo, sdi, far_sck, serial_interrupt;
    logic [3:0] seen;
    wire logic sck_pin;
    int n_fail = 0;
    int checked = 0;
    fbsp_row_type rows[9] = '{
        '{CMD, 1'b1, 32'h5, 32'h0, 1'b0}, '{CMD, 1'b0, 32'h0, 32'h5, 1'b0},
        '{CMD, 1'b1, 32'h2, 32'h0, 1'b0}, '{CMD, 1'b0, 32'h0, 32'h2, 1'b0},
        '{CMD, 1'b1, 32'h9, 32'h0, 1'b0}, '{STA, 1'b0, 32'h0, 32'h0, 1'b0},
        '{CMD, 1'b0, 32'h0, 32'h9, 1'b0}, '{12'h00C, 1'b1, 32'hF, 32'h0, 1'b1},
        '{12'h00C, 1'b0, 32'h0, 32'h0, 1'b1}};

    always #5 pclk = ~pclk;
    // The pin level is whoever drives it: the port when sck_oe is set (internal clock selected), else the far end.
    assign sck_pin = sck_oe ? sck_out : far_sck;

    fbsp_top fbsp_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo),
        .serial_interrupt(serial_interrupt)
    );
    fbsp_far_end fbsp_far_end_inst (
        .pclk(pclk), .sck_pin(sck_pin), .sdo(sdo), .sck_in(far_sck), .sdi(sdi), .seen(seen)
    );

    // =========================================================
    // Shared tasks
    // =========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    // Entered at a clock edge; one idle edge follows so the next call never collides.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic count(input logic lvl, input int lim, output int n);
        n = 0;
        while (sck_out === lvl && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : count

    task automatic wait_irq();
        int k;
        k = 0;
        while (serial_interrupt !== 1'b1 && k < 1000) begin
            @(posedge pclk);
            k++;
        end
        chk(32'(serial_interrupt), 32'h1);
    endtask : wait_irq

    task automatic end_of_test();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        logic [31:0] r;
        logic e;
        logic [3:0] w;
        int k;
        repeat (10) @(posedge pclk);
        chk(32'({pready, pslverr, sck_out, sck_oe, sdo, serial_interrupt}), 32'h0A);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d, r, e);
            if (!rows[i].w) chk(r, rows[i].exp);
            chk(32'(e), 32'(rows[i].err));
        end
        // Pass 0 clears enable mid-word and the word still completes; pass 1 clears it once the clock is already parked.
        for (int p = 0; p < 2; p++) begin
            w = p ? 4'h5 : 4'hA;
            apb(CMD, 1'b1, 32'h3, r, e);
            apb(BUF, 1'b1, 32'(w), r, e);
            apb(CMD, 1'b1, 32'hB, r, e);
            chk(32'(sck_oe), 32'h1);
            wait_irq();
            count(1'b0, 200, k);
            count(1'b1, 200, k);
            chk(32'(k), 32'd64);
            apb(STA, 1'b0, 32'h0, r, e);
            chk(32'(r[3:2]), 32'h3);
            if (p == 1) repeat (600) @(posedge pclk);
            apb(CMD, 1'b1, 32'h3, r, e);
            apb(STA, 1'b0, 32'h0, r, e);
            chk(32'(r[3]), 32'(p == 0));
            k = 0;
            while (r[3] !== 1'b0 && k < 300) begin
                apb(STA, 1'b0, 32'h0, r, e);
                k++;
            end
            chk(32'(r[3]), 32'h0);
            chk(32'(seen), 32'(w));
        end
        // External transmit: the buffer is filled and enable cleared before the far end clocks.
        apb(CMD, 1'b1, 32'h2, r, e);
        apb(BUF, 1'b1, 32'hC, r, e);
        apb(CMD, 1'b1, 32'hA, r, e);
        apb(CMD, 1'b1, 32'h2, r, e);
        fbsp_far_end_inst.send(4'h0);
        chk(32'(seen), 32'hC);
        chk(32'(serial_interrupt), 32'h1);
        fbsp_far_end_inst.send(4'h0);
        apb(STA, 1'b0, 32'h0, r, e);
        chk(32'(r[3]), 32'h0);
        for (int m = 0; m < 2; m++) begin
            w = m ? 4'h6 : 4'h9;
            apb(CMD, 1'b1, 32'h4 + 32'(2 * m), r, e);
            apb(BUF, 1'b0, 32'h0, r, e);
            chk(32'(serial_interrupt), 32'h0);
            apb(CMD, 1'b1, 32'hC + 32'(2 * m), r, e);
            fbsp_far_end_inst.send(w);
            chk(32'(serial_interrupt), 32'h1);
            apb(CMD, 1'b1, 32'h4 + 32'(2 * m), r, e);
            apb(BUF, 1'b0, 32'h0, r, e);
            chk(r, 32'(w));
            chk(32'(serial_interrupt), 32'h0);
        end
        apb(CMD, 1'b1, 32'h5, r, e);
        apb(CMD, 1'b1, 32'hD, r, e);
        wait_irq();
        repeat (700) @(posedge pclk);
        count(1'b1, 200, k);
        chk(32'(k), 32'd200);
        apb(CMD, 1'b1, 32'h5, r, e);
        apb(BUF, 1'b0, 32'h0, r, e);
        chk(32'(serial_interrupt), 32'h1);
        apb(BUF, 1'b0, 32'h0, r, e);
        chk(32'(serial_interrupt), 32'h0);
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
